/* File: core/ida_pkg.sv */
// constants for the indirect data memory access block
package ida_pkg;
  localparam int DW = 8;
  localparam int SEC_W = 3;
  localparam int ROW_W = 7;
  localparam int MEM_AW = SEC_W + ROW_W;
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam int EXT_AW = SEC_W + DW;
  // special register locations inside the shared low area
  localparam logic [7:0] ADDR_PORT0 = 8'h00;
  localparam logic [7:0] ADDR_PTR0 = 8'h01;
  localparam logic [7:0] ADDR_PORT1 = 8'h02;
  localparam logic [7:0] ADDR_PTR1_LOW = 8'h03;
  localparam logic [7:0] ADDR_PTR1_SEC = 8'h04;
  localparam logic [7:0] ADDR_PORT2 = 8'h05;
  localparam logic [7:0] ADDR_PTR2_LOW = 8'h06;
  localparam logic [7:0] ADDR_PTR2_SEC = 8'h07;
  localparam logic [7:0] ADDR_RSV_LO = 8'h78;
  localparam logic [7:0] ADDR_RAM_BASE = 8'h80;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  // pointer select codes for the increment strobe
  localparam logic [1:0] INC_PTR0 = 2'h0;
  localparam logic [1:0] INC_PTR1 = 2'h1;
  localparam logic [1:0] INC_PTR2 = 2'h2;
  localparam int READ_LATENCY = 1;
  typedef enum logic [1:0] {
    IDA_SRC_ZERO,
    IDA_SRC_PTR,
    IDA_SRC_RAM
  } ida_src_t;
endpackage

/* File: core/ida_ram.sv */
// sectored general purpose data memory with registered read data
`timescale 1ns/100ps
module ida_ram (
  // clock
  input wire logic clk_i,
  // access
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [ida_pkg::MEM_AW-1:0] addr_i,
  input wire logic [ida_pkg::DW-1:0] wdata_i,
  output logic [ida_pkg::DW-1:0] rdata_o
);
  logic [ida_pkg::DW-1:0] mem_r [ida_pkg::MEM_DEPTH];

  // contents are undefined after reset, as general memory is
  always_ff @(posedge clk_i) begin
    if (en_i && we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
    if (en_i && !we_i) begin
      rdata_o <= mem_r[addr_i];
    end
  end
endmodule

/* File: core/ida_core.sv */
// address resolver for direct, extended and indirect data memory access
`timescale 1ns/100ps
module ida_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // access request from the processor core
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic acc_ext_i,
  input wire logic [ida_pkg::EXT_AW-1:0] acc_addr_i,
  input wire logic [ida_pkg::DW-1:0] acc_wdata_i,
  // pointer increment strobe
  input wire logic ptr_inc_i,
  input wire logic [1:0] ptr_sel_i,
  // read answer
  output logic rdata_valid_o,
  output logic [ida_pkg::DW-1:0] rdata_o,
  // pointer state
  output logic [ida_pkg::DW-1:0] sector0_pointer_o,
  output logic [ida_pkg::DW-1:0] pointer_one_low_o,
  output logic [ida_pkg::DW-1:0] pointer_one_sector_o,
  output logic [ida_pkg::DW-1:0] pointer_two_low_o,
  output logic [ida_pkg::DW-1:0] pointer_two_sector_o
);
  logic [ida_pkg::DW-1:0] sector0_pointer_r;
  logic [ida_pkg::DW-1:0] pointer_one_low_r;
  logic [ida_pkg::DW-1:0] pointer_one_sector_r;
  logic [ida_pkg::DW-1:0] pointer_two_low_r;
  logic [ida_pkg::DW-1:0] pointer_two_sector_r;
  logic [ida_pkg::DW-1:0] ptr_rdata_r;
  logic rd_pend_r;
  ida_pkg::ida_src_t src_r;
  ida_pkg::ida_src_t src_nxt;

  // first stage: where the core asked to go
  wire [7:0] req_off = acc_addr_i[7:0];
  wire [ida_pkg::SEC_W-1:0] req_sec =
    acc_ext_i ? acc_addr_i[ida_pkg::EXT_AW-1:8] : '0;
  wire hit_port0 = (req_off == ida_pkg::ADDR_PORT0);
  wire hit_port1 = (req_off == ida_pkg::ADDR_PORT1);
  wire hit_port2 = (req_off == ida_pkg::ADDR_PORT2);
  wire indirect = hit_port0 || hit_port1 || hit_port2;

  // second stage: redirect through the pointer of the port hit
  // pointers are read straight from the flops, so the value seen is
  // the one standing when the instruction starts
  wire [7:0] tgt_off = hit_port0 ? sector0_pointer_r :
                       hit_port1 ? pointer_one_low_r :
                       hit_port2 ? pointer_two_low_r : req_off;
  wire [ida_pkg::SEC_W-1:0] tgt_sec =
    hit_port0 ? '0 :
    hit_port1 ? pointer_one_sector_r[ida_pkg::SEC_W-1:0] :
    hit_port2 ? pointer_two_sector_r[ida_pkg::SEC_W-1:0] : req_sec;

  // classify the final target
  wire tgt_port = (tgt_off == ida_pkg::ADDR_PORT0) ||
                  (tgt_off == ida_pkg::ADDR_PORT1) ||
                  (tgt_off == ida_pkg::ADDR_PORT2);
  wire tgt_ram = (tgt_off >= ida_pkg::ADDR_RAM_BASE);
  wire tgt_rsv = !tgt_ram && (tgt_off >= ida_pkg::ADDR_RSV_LO);
  wire tgt_ptr = (tgt_off == ida_pkg::ADDR_PTR0) ||
                 (tgt_off == ida_pkg::ADDR_PTR1_LOW) ||
                 (tgt_off == ida_pkg::ADDR_PTR1_SEC) ||
                 (tgt_off == ida_pkg::ADDR_PTR2_LOW) ||
                 (tgt_off == ida_pkg::ADDR_PTR2_SEC);
  // a port named by a pointer is not storage: no write, zero read
  wire self_ref = indirect && tgt_port;
  // reserved and unused locations never reach a pointer or the memory
  wire do_ptr = acc_valid_i && tgt_ptr && !self_ref;
  wire ptr_wr = do_ptr && acc_write_i;

  // memory side
  wire mem_en = acc_valid_i && tgt_ram;
  wire [ida_pkg::MEM_AW-1:0] mem_addr = {tgt_sec, tgt_off[6:0]};
  logic [ida_pkg::DW-1:0] mem_rdata;

  ida_ram u_ram (
    .clk_i(clk_i),
    .en_i(mem_en),
    .we_i(acc_write_i),
    .addr_i(mem_addr),
    .wdata_i(acc_wdata_i),
    .rdata_o(mem_rdata)
  );

  // pointer read mux
  wire [7:0] ptr_rd =
    (tgt_off == ida_pkg::ADDR_PTR0) ? sector0_pointer_r :
    (tgt_off == ida_pkg::ADDR_PTR1_LOW) ? pointer_one_low_r :
    (tgt_off == ida_pkg::ADDR_PTR1_SEC) ? pointer_one_sector_r :
    (tgt_off == ida_pkg::ADDR_PTR2_LOW) ? pointer_two_low_r :
    pointer_two_sector_r;

  // unused and reserved locations and self references answer zero
  always_comb begin
    src_nxt = ida_pkg::IDA_SRC_ZERO;
    if (tgt_ram) begin
      src_nxt = ida_pkg::IDA_SRC_RAM;
    end else if (do_ptr) begin
      src_nxt = ida_pkg::IDA_SRC_PTR;
    end
  end

  // per-pointer write and increment strobes
  wire wr_p0 = ptr_wr && (tgt_off == ida_pkg::ADDR_PTR0);
  wire wr_p1l = ptr_wr && (tgt_off == ida_pkg::ADDR_PTR1_LOW);
  wire wr_p1s = ptr_wr && (tgt_off == ida_pkg::ADDR_PTR1_SEC);
  wire wr_p2l = ptr_wr && (tgt_off == ida_pkg::ADDR_PTR2_LOW);
  wire wr_p2s = ptr_wr && (tgt_off == ida_pkg::ADDR_PTR2_SEC);
  wire inc_p0 = ptr_inc_i && (ptr_sel_i == ida_pkg::INC_PTR0);
  wire inc_p1 = ptr_inc_i && (ptr_sel_i == ida_pkg::INC_PTR1);
  wire inc_p2 = ptr_inc_i && (ptr_sel_i == ida_pkg::INC_PTR2);

  // a write wins over an increment in the same cycle; the 8-bit add
  // rolls over to zero and never carries into the sector pointer
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sector0_pointer_r <= ida_pkg::PTR_RESET;
      pointer_one_low_r <= ida_pkg::PTR_RESET;
      pointer_two_low_r <= ida_pkg::PTR_RESET;
    end else begin
      if (wr_p0) begin
        sector0_pointer_r <= acc_wdata_i;
      end else if (inc_p0) begin
        sector0_pointer_r <= sector0_pointer_r + 8'h01;
      end
      if (wr_p1l) begin
        pointer_one_low_r <= acc_wdata_i;
      end else if (inc_p1) begin
        pointer_one_low_r <= pointer_one_low_r + 8'h01;
      end
      if (wr_p2l) begin
        pointer_two_low_r <= acc_wdata_i;
      end else if (inc_p2) begin
        pointer_two_low_r <= pointer_two_low_r + 8'h01;
      end
    end
  end

  // sector pointers change only on a write
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pointer_one_sector_r <= ida_pkg::PTR_RESET;
      pointer_two_sector_r <= ida_pkg::PTR_RESET;
    end else begin
      if (wr_p1s) begin
        pointer_one_sector_r <= acc_wdata_i;
      end
      if (wr_p2s) begin
        pointer_two_sector_r <= acc_wdata_i;
      end
    end
  end

  // read answer one cycle after the request, direct or indirect
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_pend_r <= 1'b0;
      src_r <= ida_pkg::IDA_SRC_ZERO;
      ptr_rdata_r <= ida_pkg::DATA_ZERO;
    end else begin
      rd_pend_r <= acc_valid_i && !acc_write_i;
      if (acc_valid_i && !acc_write_i) begin
        src_r <= src_nxt;
        ptr_rdata_r <= ptr_rd;
      end
    end
  end

  // final select between registered sources
  always_comb begin
    case (src_r)
      ida_pkg::IDA_SRC_RAM: rdata_o = mem_rdata;
      ida_pkg::IDA_SRC_PTR: rdata_o = ptr_rdata_r;
      ida_pkg::IDA_SRC_ZERO: rdata_o = ida_pkg::DATA_ZERO;
      default: rdata_o = ida_pkg::DATA_ZERO;
    endcase
  end

  assign rdata_valid_o = rd_pend_r;
  assign sector0_pointer_o = sector0_pointer_r;
  assign pointer_one_low_o = pointer_one_low_r;
  assign pointer_one_sector_o = pointer_one_sector_r;
  assign pointer_two_low_o = pointer_two_low_r;
  assign pointer_two_sector_o = pointer_two_sector_r;

  // checks on the redirection and the answers
  a_redirect_one: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    acc_valid_i && hit_port1 && tgt_ram |->
    mem_en && mem_addr == {pointer_one_sector_r[2:0],
    pointer_one_low_r[6:0]})
    else $error("port one not redirected by its pointers");
  a_sector_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    acc_valid_i && hit_port0 && tgt_ram |-> mem_addr[9:7] == 3'h0)
    else $error("zero port left sector 0");
  a_port_two_sec: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    acc_valid_i && hit_port2 && tgt_ram |->
    mem_addr[9:7] == pointer_two_sector_r[2:0])
    else $error("port two ignored its sector pointer");
  a_self_read_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    acc_valid_i && !acc_write_i && self_ref |=>
    rdata_valid_o && rdata_o == 8'h00)
    else $error("self referencing read not zero");
  a_self_write_nop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    acc_valid_i && acc_write_i && self_ref && !ptr_inc_i |=>
    $stable(sector0_pointer_r) && $stable(pointer_one_low_r) &&
    $stable(pointer_two_sector_r))
    else $error("self referencing write changed storage");
  a_self_no_mem: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    self_ref |-> !mem_en)
    else $error("self referencing access reached memory");
  a_ptr_write_back: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_p1s ##1 acc_valid_i && !acc_write_i && !acc_ext_i &&
    acc_addr_i[7:0] == ida_pkg::ADDR_PTR1_SEC |=>
    rdata_o == $past(acc_wdata_i, 2))
    else $error("pointer did not read back its written value");
  a_unused_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    acc_valid_i && !acc_write_i && !tgt_ram && !tgt_ptr |=>
    rdata_o == 8'h00)
    else $error("unused location read nonzero");
  a_reserved_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    acc_valid_i && acc_write_i && tgt_rsv && !ptr_inc_i |=>
    $stable(pointer_one_sector_r) && $stable(pointer_two_low_r))
    else $error("reserved write changed state");
  a_ext_decode: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    acc_valid_i && acc_ext_i && !indirect && tgt_ram |->
    mem_addr == {acc_addr_i[10:8], acc_addr_i[6:0]})
    else $error("extended address decoded wrongly");
  a_read_latency: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    acc_valid_i && !acc_write_i ##1 !(acc_valid_i && !acc_write_i) |->
    rdata_valid_o ##1 !rdata_valid_o)
    else $error("read answer not exactly one cycle later");
  a_inc_wrap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    inc_p1 && !wr_p1l && !wr_p1s && pointer_one_low_r == 8'hFF |=>
    pointer_one_low_r == 8'h00 && $stable(pointer_one_sector_r))
    else $error("offset pointer wrap disturbed sector");
endmodule

/* File: verification/ida_cpu_model.sv */
// processor core model issuing data memory accesses to the resolver
`timescale 1ns/100ps
module ida_cpu_model (
  // clock
  input wire logic clk_i,
  // access request
  output logic acc_valid_o,
  output logic acc_write_o,
  output logic acc_ext_o,
  output logic [ida_pkg::EXT_AW-1:0] acc_addr_o,
  output logic [ida_pkg::DW-1:0] acc_wdata_o,
  // read answer
  input wire logic rdata_valid_i,
  input wire logic [ida_pkg::DW-1:0] rdata_i
);
  // idle outputs at time zero
  initial begin
    acc_valid_o = 1'b0;
    acc_write_o = 1'b0;
    acc_ext_o = 1'b0;
    acc_addr_o = 11'h000;
    acc_wdata_o = 8'h00;
  end

  // one access, called at a falling edge; valid stays up for back to back
  task automatic acc(input logic w, input logic e, input logic [10:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    acc_valid_o = 1'b1;
    acc_write_o = w;
    acc_ext_o = e;
    acc_addr_o = a;
    acc_wdata_o = d;
    @(negedge clk_i);
    // a missing answer comes back unknown so that it never matches
    q = (rdata_valid_i === 1'b1) ? rdata_i : 8'hXX;
  endtask

  // released address and write data flip so a design using stale request data is caught
  task automatic idle();
    acc_valid_o = 1'b0;
    acc_addr_o = ~acc_addr_o;
    acc_wdata_o = ~acc_wdata_o;
    @(negedge clk_i);
  endtask
endmodule

/* File: verification/tb_indirect_data_memory_access.sv */
// self-checking bench for the indirect data memory access resolver
`timescale 1ns/100ps
module tb_indirect_data_memory_access;
  logic clk_i;
  logic reset_n_i;
  logic acc_valid_i, acc_write_i, acc_ext_i, ptr_inc_i, rdata_valid_o;
  logic [10:0] acc_addr_i;
  logic [7:0] acc_wdata_i, rdata_o, p0, p1l, p1s, p2l, p2s;
  logic [1:0] ptr_sel_i;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  // free running 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  ida_core i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i),
    .acc_ext_i(acc_ext_i), .acc_addr_i(acc_addr_i),
    .acc_wdata_i(acc_wdata_i), .ptr_inc_i(ptr_inc_i),
    .ptr_sel_i(ptr_sel_i), .rdata_valid_o(rdata_valid_o),
    .rdata_o(rdata_o), .sector0_pointer_o(p0), .pointer_one_low_o(p1l),
    .pointer_one_sector_o(p1s), .pointer_two_low_o(p2l),
    .pointer_two_sector_o(p2s));

  ida_cpu_model i_cpu (.clk_i(clk_i), .acc_valid_o(acc_valid_i),
    .acc_write_o(acc_write_i), .acc_ext_o(acc_ext_i),
    .acc_addr_o(acc_addr_i), .acc_wdata_o(acc_wdata_i),
    .rdata_valid_i(rdata_valid_o), .rdata_i(rdata_o));

  task automatic close_out();
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input int e, input logic [10:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_cpu.acc(1'b1, e[0], a, d, q);
  endtask

  task automatic rd(input int e, input logic [10:0] a, input logic [7:0] x);
    logic [7:0] q;
    i_cpu.acc(1'b0, e[0], a, 8'h00, q);
    check(q, x);
  endtask

  // pointer and ram tests; addresses 0..7 are the special area
  task automatic t_ptr();
    logic [7:0] pv[5] = '{p0, p1l, p1s, p2l, p2s};
    foreach (pv[i]) check(pv[i], ida_pkg::PTR_RESET);
    for (int i = 1; i < 8; i++) begin
      if (i != 2 && i != 5) begin
        wr(0, 11'(i), 8'(8'hE0 + i));
      end
    end
    for (int i = 1; i < 8; i++) begin
      if (i != 2 && i != 5) begin
        rd(0, 11'(i), 8'(8'hE0 + i));
      end
    end
    i_cpu.idle();
    check(p2s, 8'hE7);
  endtask

  task automatic t_sector0();
    wr(1, 11'h185, 8'h3C);
    wr(0, 11'h085, 8'hC3);
    wr(0, 11'h001, 8'h85);
    rd(0, 11'h000, 8'hC3);
    wr(0, 11'h000, 8'h5A);
    rd(0, 11'h085, 8'h5A);
    rd(1, 11'h185, 8'h3C);
    i_cpu.idle();
  endtask

  task automatic t_sectors();
    wr(0, 11'h0F0, 8'h11);
    wr(1, 11'h1F0, 8'hA5);
    wr(1, 11'h2F0, 8'h96);
    wr(1, 11'h7F0, 8'h77);
    rd(0, 11'h0F0, 8'h11);
    wr(0, 11'h004, 8'h01);
    wr(0, 11'h003, 8'hF0);
    rd(0, 11'h002, 8'hA5);
    wr(0, 11'h004, 8'h07);
    rd(0, 11'h002, 8'h77);
    wr(0, 11'h007, 8'h02);
    wr(0, 11'h006, 8'hF0);
    wr(0, 11'h005, 8'h69);
    rd(1, 11'h2F0, 8'h69);
    i_cpu.idle();
  endtask

  task automatic t_self();
    wr(0, 11'h001, 8'h00);
    rd(0, 11'h000, 8'h00);
    wr(0, 11'h004, 8'h00);
    wr(0, 11'h003, 8'h05);
    wr(0, 11'h002, 8'hAA);
    rd(0, 11'h002, 8'h00);
    rd(0, 11'h005, 8'h69);
    wr(0, 11'h003, 8'h02);
    rd(0, 11'h002, 8'h00);
    i_cpu.idle();
    check(p2l, 8'hF0);
  endtask

  task automatic t_special();
    rd(0, 11'h010, 8'h00);
    rd(0, 11'h077, 8'h00);
    wr(0, 11'h078, 8'hFF);
    rd(0, 11'h078, 8'h00);
    rd(0, 11'h07F, 8'h00);
    i_cpu.idle();
  endtask

  // back to back: a pointer written one cycle steers the next access
  task automatic t_b2b();
    wr(0, 11'h090, 8'h12);
    wr(0, 11'h091, 8'h34);
    wr(0, 11'h001, 8'h90);
    rd(0, 11'h000, 8'h12);
    wr(0, 11'h001, 8'h91);
    rd(0, 11'h000, 8'h34);
    i_cpu.idle();
  endtask

  task automatic inc(input logic [1:0] s);
    ptr_inc_i = 1'b1;
    ptr_sel_i = s;
    @(negedge clk_i);
    ptr_inc_i = 1'b0;
    ptr_sel_i = 2'h3;
    @(negedge clk_i);
  endtask

  task automatic t_wrap();
    wr(0, 11'h003, 8'hFF);
    wr(0, 11'h004, 8'h03);
    // read straight after the write: the new value must already answer
    rd(0, 11'h004, 8'h03);
    i_cpu.idle();
    inc(ida_pkg::INC_PTR1);
    check(p1l, 8'h00);
    check(p1s, 8'h03);
    inc(ida_pkg::INC_PTR0);
    check(p0, 8'h92);
    inc(ida_pkg::INC_PTR2);
    check(p2l, 8'hF1);
  endtask

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    reset_n_i = 1'b0;
    ptr_inc_i = 1'b0;
    ptr_sel_i = 2'h3;
    repeat (8) @(negedge clk_i);
    reset_n_i = 1'b1;
    t_ptr();
    t_sector0();
    t_sectors();
    t_self();
    t_special();
    t_b2b();
    t_wrap();
    close_out();
  end
endmodule
